/* logic/ctpc_timer_pairs.v */
// Function
// R1: two-bit select picks counter clock source
// R2: cascade bit 5 joins pair into 16 bits
// R3: cascaded high counter advances on low overflow
// R4: cascaded pair suppresses low timer interrupt
// R5: 8-bit one-shot clears and stops on match
// R6: cascaded one-shot matches full 16-bit value
// R7: high one-shot bit ignored while cascaded
// R8: high clock select ignored while cascaded
// R9: software rewrites mode only while stopped; the code accepts mode writes while running
// R10: run bit 0 starts and stops counting
// R11: status bit 7 shows counting in progress
// R12: cascaded high counts regardless of run bit
// R13: cascaded high status flag reads zero
// R14: third pair cascade bit sits at 2
// R15: mode 8/16-bit, run 8-bit, reset zero
// R16: counter write clears, cascaded clears both
// R17: cascaded low counter read latches high counter
// R18: status follows run on selected clock
// R19: one-shot match also clears run bit
`timescale 1ns/10ps
`default_nettype none
`include "ctpc_defines.vh"

module ctpc_timer_pairs
(
	// clock and reset
	input wire clk_in,
	input wire rst_in,
	// timer clock pins
	input wire slow_clock_in,
	input wire time_base_clock_in,
	// axi4-lite write address
	input wire s_axi_awvalid_in,
	output wire s_axi_awready_out,
	input wire [`CTPC_ADDR_W-1:0] s_axi_awaddr_in,
	input wire [2:0] s_axi_awprot_in,
	// axi4-lite write data
	input wire s_axi_wvalid_in,
	output wire s_axi_wready_out,
	input wire [31:0] s_axi_wdata_in,
	input wire [3:0] s_axi_wstrb_in,
	// axi4-lite write response
	output wire s_axi_bvalid_out,
	input wire s_axi_bready_in,
	output wire [1:0] s_axi_bresp_out,
	// axi4-lite read address
	input wire s_axi_arvalid_in,
	output wire s_axi_arready_out,
	input wire [`CTPC_ADDR_W-1:0] s_axi_araddr_in,
	input wire [2:0] s_axi_arprot_in,
	// axi4-lite read data
	output wire s_axi_rvalid_out,
	input wire s_axi_rready_in,
	output wire [31:0] s_axi_rdata_out,
	output wire [1:0] s_axi_rresp_out,
	// interrupt
	output wire irq_out
);

	// 0 none, 1 byte only, 2 byte or halfword, 3 full word
	function [1:0] ctpc_kind;
		input [15:0] ix;
		begin
			case (ix)
				`CTPC_IX_P89_LMODE, `CTPC_IX_P89_HMODE, `CTPC_IX_PAB_LMODE,
				`CTPC_IX_PAB_HMODE, `CTPC_IX_PEF_LMODE, `CTPC_IX_PEF_HMODE:
					ctpc_kind = 2'd2;
				`CTPC_IX_P89_LRUN, `CTPC_IX_P89_HRUN, `CTPC_IX_PAB_LRUN,
				`CTPC_IX_PAB_HRUN, `CTPC_IX_PEF_LRUN, `CTPC_IX_PEF_HRUN:
					ctpc_kind = 2'd1;
				`CTPC_IX_IRQ_STAT, `CTPC_IX_IRQ_MASK:
					ctpc_kind = 2'd3;
				default:
					ctpc_kind = (ix[15:4] == `CTPC_IX_CNT_BASE >> 4 && ix[3:0] < 4'hC) ? 2'd1 : 2'd0;
			endcase
		end
	endfunction

	// pin synchronisers; stage two feeds the edge detector, stage one nothing else
	reg [2:0] slow_sync_reg;
	reg [2:0] tb_sync_reg;
	reg [5:0] tb_div_reg;
	wire slow_tick = slow_sync_reg[1] & ~slow_sync_reg[2];
	wire tb_tick = tb_sync_reg[1] & ~tb_sync_reg[2];
	wire tick64 = tb_tick & (tb_div_reg == `CTPC_DIV64_LAST);
	wire tick16 = tb_tick & (tb_div_reg[3:0] == `CTPC_DIV16_LAST);
	wire [3:0] src_ticks = {tick16, tick64, tb_tick, slow_tick}; // R1

	always @(posedge clk_in)
	begin
		if (rst_in)
		begin
			slow_sync_reg <= 3'h0;
			tb_sync_reg <= 3'h0;
			tb_div_reg <= 6'h00;
		end
		else
		begin
			slow_sync_reg <= {slow_sync_reg[1:0], slow_clock_in};
			tb_sync_reg <= {tb_sync_reg[1:0], time_base_clock_in};
			if (tb_tick)
				tb_div_reg <= tb_div_reg + 6'h01;
		end
	end

	// bus slave state
	reg awready_reg;
	reg wready_reg;
	reg bvalid_reg;
	reg [1:0] bresp_reg;
	reg arready_reg;
	reg rvalid_reg;
	reg [31:0] rdata_reg;
	reg [1:0] rresp_reg;
	reg aw_hold_reg;
	reg w_hold_reg;
	reg rd_pend_reg;
	reg [`CTPC_ADDR_W-1:0] awaddr_reg;
	reg [`CTPC_ADDR_W-1:0] araddr_reg;
	reg [31:0] wdata_reg;
	reg [3:0] wstrb_reg;
	reg [5:0] irq_stat_reg;
	reg [5:0] irq_mask_reg;
	reg irq_reg;

	wire aw_take = s_axi_awvalid_in & awready_reg;
	wire w_take = s_axi_wvalid_in & wready_reg;
	wire ar_take = s_axi_arvalid_in & arready_reg;
	wire wr_fire = aw_hold_reg & w_hold_reg & ~bvalid_reg;
	wire rd_fire = rd_pend_reg;

	wire [15:0] wr_ix = awaddr_reg[`CTPC_ADDR_W-1:2];
	wire [15:0] rd_ix = araddr_reg[`CTPC_ADDR_W-1:2];
	wire [1:0] wr_kind = ctpc_kind(wr_ix);
	wire [1:0] rd_kind = ctpc_kind(rd_ix);
	// narrow registers refuse lanes they do not have
	wire wr_bad = (awaddr_reg[1:0] != 2'b00) || (wr_kind == 2'd0) ||
		(wr_kind == 2'd1 && wstrb_reg[3:1] != 3'b000) ||
		(wr_kind == 2'd2 && wstrb_reg[3:2] != 2'b00); // R15
	wire rd_bad = (araddr_reg[1:0] != 2'b00) || (rd_kind == 2'd0);
	wire wr_ok = wr_fire & ~wr_bad & wstrb_reg[0];
	wire rd_ok = rd_fire & ~rd_bad;
	wire [7:0] wd = wdata_reg[7:0];

	wire aw_hold_next = wr_fire ? 1'b0 : (aw_take ? 1'b1 : aw_hold_reg);
	wire w_hold_next = wr_fire ? 1'b0 : (w_take ? 1'b1 : w_hold_reg);
	wire bvalid_next = wr_fire ? 1'b1 : ((bvalid_reg & s_axi_bready_in) ? 1'b0 : bvalid_reg);
	wire rd_pend_next = ar_take;
	wire rvalid_next = rd_fire ? 1'b1 : ((rvalid_reg & s_axi_rready_in) ? 1'b0 : rvalid_reg);

	wire [5:0] events;
	wire [23:0] pair_rdata;
	wire [5:0] stat_next = (irq_stat_reg &
		~((wr_ok && wr_ix == `CTPC_IX_IRQ_STAT) ? wd[5:0] : 6'h00)) | events;

	always @(posedge clk_in)
	begin
		if (rst_in)
		begin
			awready_reg <= 1'b0;
			wready_reg <= 1'b0;
			bvalid_reg <= 1'b0;
			bresp_reg <= `CTPC_RESP_OKAY;
			arready_reg <= 1'b0;
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h00000000;
			rresp_reg <= `CTPC_RESP_OKAY;
			aw_hold_reg <= 1'b0;
			w_hold_reg <= 1'b0;
			rd_pend_reg <= 1'b0;
			awaddr_reg <= {`CTPC_ADDR_W{1'b0}};
			araddr_reg <= {`CTPC_ADDR_W{1'b0}};
			wdata_reg <= 32'h00000000;
			wstrb_reg <= 4'h0;
			irq_stat_reg <= 6'h00;
			irq_mask_reg <= 6'h00;
			irq_reg <= 1'b0;
		end
		else
		begin
			aw_hold_reg <= aw_hold_next;
			w_hold_reg <= w_hold_next;
			bvalid_reg <= bvalid_next;
			rd_pend_reg <= rd_pend_next;
			rvalid_reg <= rvalid_next;
			awready_reg <= ~aw_hold_next & ~bvalid_next;
			wready_reg <= ~w_hold_next & ~bvalid_next;
			arready_reg <= ~rd_pend_next & ~rvalid_next;
			if (aw_take)
				awaddr_reg <= s_axi_awaddr_in;
			if (w_take)
			begin
				wdata_reg <= s_axi_wdata_in;
				wstrb_reg <= s_axi_wstrb_in;
			end
			if (ar_take)
				araddr_reg <= s_axi_araddr_in;
			if (wr_fire)
				bresp_reg <= wr_bad ? `CTPC_RESP_SLVERR : `CTPC_RESP_OKAY;
			if (rd_fire)
			begin
				rresp_reg <= rd_bad ? `CTPC_RESP_SLVERR : `CTPC_RESP_OKAY;
				if (!rd_ok)
					rdata_reg <= 32'h00000000;
				else if (rd_ix == `CTPC_IX_IRQ_STAT)
					rdata_reg <= {26'h0000000, irq_stat_reg};
				else if (rd_ix == `CTPC_IX_IRQ_MASK)
					rdata_reg <= {26'h0000000, irq_mask_reg};
				else
					rdata_reg <= {24'h000000, pair_rdata[7:0] | pair_rdata[15:8] | pair_rdata[23:16]};
			end
			// a new event in the clearing cycle survives the clear
			irq_stat_reg <= stat_next;
			if (wr_ok && wr_ix == `CTPC_IX_IRQ_MASK)
				irq_mask_reg <= wd[5:0];
			irq_reg <= |(stat_next & ((wr_ok && wr_ix == `CTPC_IX_IRQ_MASK) ? wd[5:0] : irq_mask_reg));
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi = gi + 1)
		begin : pair
			localparam [15:0] LM_IX = gi == 0 ? `CTPC_IX_P89_LMODE :
				gi == 1 ? `CTPC_IX_PAB_LMODE : `CTPC_IX_PEF_LMODE;
			localparam [15:0] LR_IX = gi == 0 ? `CTPC_IX_P89_LRUN :
				gi == 1 ? `CTPC_IX_PAB_LRUN : `CTPC_IX_PEF_LRUN;
			localparam [15:0] HM_IX = gi == 0 ? `CTPC_IX_P89_HMODE :
				gi == 1 ? `CTPC_IX_PAB_HMODE : `CTPC_IX_PEF_HMODE;
			localparam [15:0] HR_IX = gi == 0 ? `CTPC_IX_P89_HRUN :
				gi == 1 ? `CTPC_IX_PAB_HRUN : `CTPC_IX_PEF_HRUN;
			// spelled out per pair so no integer product is narrowed
			localparam [15:0] LC_IX = gi == 0 ? `CTPC_IX_CNT_BASE :
				gi == 1 ? `CTPC_IX_CNT_BASE + 16'h0004 : `CTPC_IX_CNT_BASE + 16'h0008;
			localparam [15:0] HC_IX = LC_IX + 16'h0001;
			localparam [15:0] LD_IX = LC_IX + 16'h0002;
			localparam [15:0] HD_IX = LC_IX + 16'h0003;
			localparam CB = gi == 2 ? `CTPC_ALT_CASC_BIT : `CTPC_CASC_BIT; // R14
			localparam [7:0] LMASK = gi == 2 ? `CTPC_ALT_LMODE_WMASK : `CTPC_LMODE_WMASK;

			reg [7:0] lmode_reg;
			reg [7:0] hmode_reg;
			reg low_run_bit_reg;
			reg high_run_bit_reg;
			reg low_counting_flag_reg;
			reg high_counting_flag_reg;
			reg [7:0] low_counter_reg;
			reg [7:0] high_counter_reg;
			reg [7:0] low_compare_value_reg;
			reg [7:0] high_compare_value_reg;
			reg [7:0] high_latch_reg;

			wire casc = lmode_reg[CB]; // R2
			wire ltick = src_ticks[lmode_reg[1:0]]; // R1
			wire htick = src_ticks[hmode_reg[1:0]] & ~casc; // R8
			wire lcount = low_counting_flag_reg & ltick;
			wire hcount = high_counting_flag_reg & htick;
			wire lmatch = low_counter_reg == low_compare_value_reg;
			wire hmatch = high_counter_reg == high_compare_value_reg;
			wire lev = lcount & lmatch & ~casc; // R4
			wire hev = hcount & hmatch;
			wire cev = lcount & casc & lmatch & hmatch; // R6
			wire lovf = lcount & (low_counter_reg == 8'hFF);
			wire l_oneshot = lmode_reg[`CTPC_OST_BIT];
			wire h_oneshot = hmode_reg[`CTPC_OST_BIT] & ~casc; // R7
			wire l_stop = (lev | cev) & l_oneshot; // R5 R6
			wire h_stop = hev & h_oneshot; // R5
			wire wr_lc = wr_ok && wr_ix == LC_IX;
			wire wr_hc = wr_ok && wr_ix == HC_IX;

			assign events[2 * gi] = lev; // R4
			assign events[2 * gi + 1] = hev | cev;

			always @(posedge clk_in)
			begin
				if (rst_in)
				begin
					lmode_reg <= `CTPC_RESET_BYTE; // R15
					hmode_reg <= `CTPC_RESET_BYTE;
					low_run_bit_reg <= 1'b0;
					high_run_bit_reg <= 1'b0;
					low_counting_flag_reg <= 1'b0;
					high_counting_flag_reg <= 1'b0;
					low_counter_reg <= 8'h00;
					high_counter_reg <= 8'h00;
					low_compare_value_reg <= 8'h00;
					high_compare_value_reg <= 8'h00;
					high_latch_reg <= 8'h00;
				end
				else
				begin
					// mode changes while running are the caller's fault, not blocked
					if (wr_ok && wr_ix == LM_IX)
						lmode_reg <= wd & LMASK; // R9
					if (wr_ok && wr_ix == HM_IX)
						hmode_reg <= wd & `CTPC_HMODE_WMASK;
					if (wr_ok && wr_ix == LD_IX)
						low_compare_value_reg <= wd;
					if (wr_ok && wr_ix == HD_IX)
						high_compare_value_reg <= wd;

					// a one-shot stop overrides a run write in the same cycle
					if (l_stop)
						low_run_bit_reg <= 1'b0; // R19
					else if (wr_ok && wr_ix == LR_IX)
						low_run_bit_reg <= wd[`CTPC_RUN_BIT]; // R10
					if (h_stop)
						high_run_bit_reg <= 1'b0; // R19
					else if (wr_ok && wr_ix == HR_IX)
						high_run_bit_reg <= wd[`CTPC_RUN_BIT]; // R10

					// start and stop take effect on the next selected tick
					if (l_stop)
						low_counting_flag_reg <= 1'b0;
					else if (ltick)
						low_counting_flag_reg <= low_run_bit_reg; // R18
					if (casc | h_stop)
						high_counting_flag_reg <= 1'b0; // R13
					else if (src_ticks[hmode_reg[1:0]])
						high_counting_flag_reg <= high_run_bit_reg; // R18

					if (wr_lc | (wr_hc & casc))
						low_counter_reg <= 8'h00; // R16
					else if (lcount)
						low_counter_reg <= (casc ? (lmatch & hmatch) : lmatch) ? 8'h00 :
							low_counter_reg + 8'h01;

					if (wr_hc | (wr_lc & casc))
						high_counter_reg <= 8'h00; // R16
					else if (cev)
						high_counter_reg <= 8'h00;
					else if (casc & lovf)
						high_counter_reg <= high_counter_reg + 8'h01; // R3 R12
					else if (hcount)
						high_counter_reg <= hmatch ? 8'h00 : high_counter_reg + 8'h01;

					if (rd_ok && rd_ix == LC_IX && casc)
						high_latch_reg <= high_counter_reg; // R17
				end
			end

			assign pair_rdata[8 * gi +: 8] = !rd_ok ? 8'h00 :
				rd_ix == LM_IX ? lmode_reg :
				rd_ix == HM_IX ? hmode_reg :
				rd_ix == LR_IX ? {low_counting_flag_reg, 6'h00, low_run_bit_reg} : // R11
				rd_ix == HR_IX ? {high_counting_flag_reg & ~casc, 6'h00, high_run_bit_reg} : // R13
				rd_ix == LC_IX ? low_counter_reg :
				rd_ix == HC_IX ? (casc ? high_latch_reg : high_counter_reg) : // R17
				rd_ix == LD_IX ? low_compare_value_reg :
				rd_ix == HD_IX ? high_compare_value_reg : 8'h00;
		end
	endgenerate

	assign s_axi_awready_out = awready_reg;
	assign s_axi_wready_out = wready_reg;
	assign s_axi_bvalid_out = bvalid_reg;
	assign s_axi_bresp_out = bresp_reg;
	assign s_axi_arready_out = arready_reg;
	assign s_axi_rvalid_out = rvalid_reg;
	assign s_axi_rdata_out = rdata_reg;
	assign s_axi_rresp_out = rresp_reg;
	assign irq_out = irq_reg;

endmodule
`default_nettype wire

/* logic/ctpc_defines.vh */
`ifndef CTPC_DEFINES_VH
`define CTPC_DEFINES_VH

// register indexes; byte address is four times the index
`define CTPC_ADDR_W 18
`define CTPC_IX_P89_LMODE 16'hF8E2
`define CTPC_IX_P89_LRUN 16'hF8E3
`define CTPC_IX_P89_HMODE 16'hF8E6
`define CTPC_IX_P89_HRUN 16'hF8E7
`define CTPC_IX_PAB_LMODE 16'hF8EA
`define CTPC_IX_PAB_LRUN 16'hF8EB
`define CTPC_IX_PAB_HMODE 16'hF8EE
`define CTPC_IX_PAB_HRUN 16'hF8EF
`define CTPC_IX_PEF_LMODE 16'hF362
`define CTPC_IX_PEF_LRUN 16'hF363
`define CTPC_IX_PEF_HMODE 16'hF36A
`define CTPC_IX_PEF_HRUN 16'hF36B
// counters and compare values: base + 4 * pair + {0 lcnt, 1 hcnt, 2 lcmp, 3 hcmp}
`define CTPC_IX_CNT_BASE 16'hF900
`define CTPC_IX_IRQ_STAT 16'hF910
`define CTPC_IX_IRQ_MASK 16'hF911

// field positions
`define CTPC_OST_BIT 7
`define CTPC_CASC_BIT 5
`define CTPC_ALT_CASC_BIT 2
`define CTPC_STAT_BIT 7
`define CTPC_RUN_BIT 0

// writable bits of each mode register
`define CTPC_LMODE_WMASK 8'hA3
`define CTPC_ALT_LMODE_WMASK 8'h87
`define CTPC_HMODE_WMASK 8'h83
`define CTPC_RESET_BYTE 8'h00

// time base dividers
`define CTPC_DIV64_LAST 6'h3F
`define CTPC_DIV16_LAST 4'hF

`define CTPC_RESP_OKAY 2'b00
`define CTPC_RESP_SLVERR 2'b10

`endif

/* testbench/ctpc_monitor.sv */
`timescale 1ns/10ps
`default_nettype none
module ctpc_monitor
(
	// clock and reset
	input wire clk_in,
	input wire rst_in,
	// register bus handshakes
	input wire s_axi_awvalid_in,
	input wire s_axi_awready_out,
	input wire s_axi_wvalid_in,
	input wire s_axi_wready_out,
	input wire s_axi_bvalid_out,
	input wire s_axi_bready_in,
	input wire [1:0] s_axi_bresp_out,
	input wire s_axi_arvalid_in,
	input wire s_axi_arready_out,
	input wire s_axi_rvalid_out,
	input wire s_axi_rready_in,
	input wire [31:0] s_axi_rdata_out,
	// interrupt
	input wire irq_out
);
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (rst_in);
	AST_RST_IDLE: assert property (disable iff (1'b0) rst_in |=> !s_axi_bvalid_out && !s_axi_rvalid_out && !irq_out) else $error("idle after reset");
	AST_B_TIME: assert property (s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out |=> !s_axi_bvalid_out ##1 s_axi_bvalid_out) else $error("write answer timing");
	AST_R_TIME: assert property (s_axi_arvalid_in && s_axi_arready_out |=> !s_axi_rvalid_out ##1 s_axi_rvalid_out) else $error("read answer timing");
	AST_B_HOLD: assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out && $stable(s_axi_bresp_out)) else $error("write answer dropped");
	AST_B_DONE: assert property (s_axi_bvalid_out && s_axi_bready_in |=> !s_axi_bvalid_out && s_axi_awready_out && s_axi_wready_out) else $error("write not closed");
	AST_R_DONE: assert property (s_axi_rvalid_out && s_axi_rready_in |=> !s_axi_rvalid_out && s_axi_arready_out) else $error("read not closed");
	AST_W_BUSY: assert property (s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out) else $error("write taken while busy");
	AST_UPPER_ZERO: assert property (s_axi_rvalid_out |-> s_axi_rdata_out[31:8] == 24'h000000) else $error("upper read bits set");
	cover property (s_axi_bvalid_out && s_axi_bresp_out == 2'b10);
	cover property (s_axi_rvalid_out && s_axi_rdata_out[7]);
	cover property ($rose(irq_out));
endmodule
bind ctpc_timer_pairs ctpc_monitor u_mon (.clk_in, .rst_in, .s_axi_awvalid_in, .s_axi_awready_out,
	.s_axi_wvalid_in, .s_axi_wready_out, .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_bresp_out,
	.s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rvalid_out, .s_axi_rready_in,
	.s_axi_rdata_out, .irq_out);
`default_nettype wire

/* testbench/tb.sv */
`timescale 1ns/10ps
`default_nettype none
`include "ctpc_defines.vh"
module tb;
	logic clk_in = 0, rst_in = 1, slw = 0, tbc = 0;
	logic awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
	logic awr, wr, bv, arr, rv, irq;
	logic [17:0] awa = 0, ara = 0;
	logic [31:0] wd = 0, rd;
	logic [3:0] ws = 0;
	logic [1:0] br, rr;
	logic [7:0] rnd = 8'h61, v, lo, hi;
	logic [15:0] mix [6] = '{16'hF8E2, 16'hF8E6, 16'hF8EA, 16'hF8EE, 16'hF362, 16'hF36A};
	int n_fail = 0, n_compared = 0, cyc = 0;
	localparam [1:0] OK = `CTPC_RESP_OKAY;
	localparam [1:0] ER = `CTPC_RESP_SLVERR;
	ctpc_timer_pairs DUT (.clk_in(clk_in), .rst_in(rst_in), .slow_clock_in(slw),
		.time_base_clock_in(tbc), .s_axi_awvalid_in(awv), .s_axi_awready_out(awr),
		.s_axi_awaddr_in(awa), .s_axi_awprot_in(3'h0), .s_axi_wvalid_in(wv),
		.s_axi_wready_out(wr), .s_axi_wdata_in(wd), .s_axi_wstrb_in(ws), .s_axi_bvalid_out(bv),
		.s_axi_bready_in(bry), .s_axi_bresp_out(br), .s_axi_arvalid_in(arv),
		.s_axi_arready_out(arr), .s_axi_araddr_in(ara), .s_axi_arprot_in(3'h0),
		.s_axi_rvalid_out(rv), .s_axi_rready_in(rry), .s_axi_rdata_out(rd),
		.s_axi_rresp_out(rr), .irq_out(irq));
	initial
	begin
		forever #20 clk_in = ~clk_in;
	end
	function automatic [7:0] lfsr(input [7:0] s);
		lfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	// writable bits per mode register; third pair keeps its cascade bit at 2
	function automatic [7:0] wmask(input int i);
		wmask = (i == 4) ? 8'h87 : (i[0] ? 8'h83 : 8'hA3);
	endfunction
	task automatic summarize;
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(input [31:0] got, input [31:0] exp, input string m);
		n_compared++;
		if (got !== exp)
		begin
			n_fail++;
			$display("wrong value %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	task automatic chkr(input [1:0] got, input [1:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			n_fail++;
			$display("wrong value %0t response %b exp %b", $time, got, exp);
		end
	endtask
	// bready raised only after the answer so a held answer is exercised
	task automatic wrc(input [15:0] ix, input [7:0] d, input [3:0] s, input [1:0] er);
		bit pa, pw;
		pa = 1;
		pw = 1;
		awa <= {ix, 2'b00};
		wd <= {24'h000000, d};
		ws <= s;
		awv <= 1;
		wv <= 1;
		while (pa || pw)
		begin
			@(posedge clk_in);
			if (pa && awr)
			begin
				pa = 0;
				awv <= 0;
			end
			if (pw && wr)
			begin
				pw = 0;
				wv <= 0;
			end
		end
		while (!bv) @(posedge clk_in);
		bry <= 1;
		@(posedge clk_in);
		bry <= 0;
		chkr(br, er);
	endtask
	task automatic rdq(input [15:0] ix, output [7:0] d);
		ara <= {ix, 2'b00};
		arv <= 1;
		rry <= 1;
		do @(posedge clk_in); while (!arr);
		arv <= 0;
		do @(posedge clk_in); while (!rv);
		rry <= 0;
		d = rd[7:0];
		chk(rd[31:8], 0, "upper");
		chkr(rr, (ix[15:8] == 8'h00) ? ER : OK);
	endtask
	task automatic rdc(input [15:0] ix, input [7:0] e);
		logic [7:0] d;
		rdq(ix, d);
		chk(d, e, "register");
	endtask
	task automatic pulse(input int n, input bit s);
		repeat (n)
		begin
			if (s) tbc <= 1; else slw <= 1;
			repeat (3) @(posedge clk_in);
			if (s) tbc <= 0; else slw <= 0;
			repeat (3) @(posedge clk_in);
		end
		repeat (6) @(posedge clk_in);
	endtask
	always @(posedge clk_in)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			n_fail++;
			$display("wrong value %0t timeout", $time);
			summarize;
		end
	end
	initial
	begin
		repeat (3) @(posedge clk_in);
		rst_in <= 0;
		@(posedge clk_in);
		for (int i = 0; i < 6; i++)
		begin
			rdc(mix[i], 0);
			rdc(mix[i] + 1, 0);
			rnd = lfsr(rnd);
			wrc(mix[i], rnd, 4'h3, OK);
			rdc(mix[i], rnd & wmask(i));
			rnd = lfsr(rnd);
			wrc(mix[i] + 1, rnd, 4'h1, OK);
			rdc(mix[i] + 1, rnd & 8'h01);
			wrc(mix[i] + 1, rnd, 4'h2, ER);
			wrc(mix[i] + 1, 0, 4'h1, OK);
			wrc(mix[i], 0, 4'h1, OK);
		end
		wrc(16'h0000, 8'h01, 4'h1, ER);
		rdc(16'h0000, 0);
		wrc(16'hF906, 8'h05, 4'h1, OK);
		wrc(16'hF911, 8'h04, 4'h1, OK);
		wrc(16'hF8EA, 8'h81, 4'h1, OK);
		wrc(16'hF8EB, 8'h01, 4'h1, OK);
		pulse(4, 1);
		rdc(16'hF8EB, 8'h81);
		pulse(10, 1);
		rdc(16'hF904, 0);
		rdc(16'hF8EB, 0);
		chk(irq, 1, "irq");
		wrc(16'hF910, 8'h04, 4'h1, OK);
		rdc(16'hF910, 0);
		chk(irq, 0, "irq clear");
		wrc(16'hF906, 8'hFF, 4'h1, OK);
		wrc(16'hF8EA, 8'h00, 4'h1, OK);
		wrc(16'hF8EB, 8'h01, 4'h1, OK);
		pulse(6, 1);
		rdc(16'hF904, 0);
		pulse(3, 0);
		rdq(16'hF904, v);
		chk(v >= 1 && v <= 3, 1, "slow count");
		wrc(16'hF902, 8'h80, 4'h1, OK);
		wrc(16'hF903, 8'h01, 4'h1, OK);
		wrc(16'hF8E6, 8'h82, 4'h1, OK);
		wrc(16'hF8E2, 8'hA1, 4'h1, OK);
		wrc(16'hF911, 8'h03, 4'h1, OK);
		wrc(16'hF8E3, 8'h01, 4'h1, OK);
		pulse(300, 1);
		rdq(16'hF900, lo);
		rdq(16'hF901, hi);
		chk({hi, lo} >= 16'h0124 && {hi, lo} <= 16'h012C, 1, "cascade count");
		rdc(16'hF8E7, 0);
		rdc(16'hF8E3, 8'h81);
		chk(irq, 0, "low irq");
		wrc(16'hF901, 8'h5A, 4'h1, OK);
		rdc(16'hF900, 0);
		rdc(16'hF901, 0);
		pulse(400, 1);
		rdc(16'hF900, 0);
		rdc(16'hF901, 0);
		rdc(16'hF8E3, 0);
		rdc(16'hF910, 8'h02);
		chk(irq, 1, "high irq");
		wrc(16'hF911, 0, 4'h1, OK);
		repeat (3) @(posedge clk_in);
		chk(irq, 0, "masked");
		summarize;
	end
endmodule
`default_nettype wire
